// ---- core/tacb_edge_if.sv ----
// carrier for one synchronised pin level and its falling edge pulse
`timescale 1ns/1ps
`default_nettype none
interface tacb_edge_if;
    logic level; // synchronised pin level
    logic fall;  // one-cycle pulse on a 1-to-0 transition
    modport source (output level, output fall);
    modport sink (input level, input fall);
endinterface
`default_nettype wire

// ---- core/tacb_edge_sync.sv ----
// two-flop synchroniser with falling edge detector for one pin
`timescale 1ns/1ps
`default_nettype none
module tacb_edge_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // raw pin from outside the clock domain
    input wire logic pin,
    // synchronised level and edge
    tacb_edge_if.source edge_out
);

    // all state of the synchroniser
    typedef struct packed {
        logic meta;  // first flop, read only by the second
        logic sync;  // second flop, safe to use
        logic prev;  // previous synchronised sample
    } tacb_sync_type;

    tacb_sync_type s_q;
    tacb_sync_type s_d;

    // next state: shift the pin through the chain
    always_comb begin
        s_d = s_q;
        s_d.meta = pin;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    // register; idle high so a pin held high at reset gives no false edge, while a pin held low at reset gives one falling edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // edge compares successive synchronised samples only
    assign edge_out.level = s_q.sync;
    assign edge_out.fall = s_q.prev & ~s_q.sync;

endmodule
`default_nettype wire

// ---- core/tacb_pkg.sv ----
// constants, types and register map of the 16-bit timer with reload, capture and baud ticks
package tacb_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] ADDR_RCAP_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RCAP_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

    // control register bit positions
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_EXTERNAL_FLAG = 6;
    localparam int BIT_RX_BAUD_SELECT = 5;
    localparam int BIT_TX_BAUD_SELECT = 4;
    localparam int BIT_EXTERNAL_ENABLE = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_COUNTER_SELECT = 1;
    localparam int BIT_CAPTURE_SELECT = 0;

    // reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [15:0] RESET_COUNT = 16'h0000;
    localparam logic [15:0] RESET_RCAP = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // operating modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_AUTORELOAD = 2'b01,
        MODE_CAPTURE = 2'b10,
        MODE_BAUD = 2'b11
    } tacb_mode_type;

endpackage

// ---- core/tacb_timer.sv ----
// 16-bit timer/counter with autoreload, capture and baud tick generation
`timescale 1ns/1ps
`default_nettype none
module tacb_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    // external pins
    input wire logic count_pin,
    input wire logic trigger_pin,
    // serial port baud ticks
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    // interrupt request to the interrupt controller
    output logic irq
);

    // all state of the timer
    typedef struct packed {
        logic [7:0] control;   // timer2_control
        logic [15:0] count;    // count_high:count_low
        logic [15:0] rcap;     // reload_capture_high:reload_capture_low
        logic [7:0] rdata;     // registered read data
        logic rvalid;          // read answer strobe
        logic rx_tick;         // overflow pulse to the receiver
        logic tx_tick;         // overflow pulse to the transmitter
    } tacb_state_type;

    tacb_state_type s_q;
    tacb_state_type s_d;

    // synchronised pins
    tacb_edge_if count_edge ();
    tacb_edge_if trigger_edge ();

    // count pin through its synchroniser
    tacb_edge_sync u_count_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(count_pin),
        .edge_out(count_edge)
    );

    // trigger pin through its synchroniser
    tacb_edge_sync u_trigger_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(trigger_pin),
        .edge_out(trigger_edge)
    );

    // decode the operating mode from the control byte
    function automatic tacb_pkg::tacb_mode_type decode_mode(input logic [7:0] ctl);
        tacb_pkg::tacb_mode_type m;
        if (!ctl[tacb_pkg::BIT_RUN]) begin
            m = tacb_pkg::MODE_OFF;
        end else if (ctl[tacb_pkg::BIT_RX_BAUD_SELECT] || ctl[tacb_pkg::BIT_TX_BAUD_SELECT]) begin
            m = tacb_pkg::MODE_BAUD;
        end else if (ctl[tacb_pkg::BIT_CAPTURE_SELECT]) begin
            m = tacb_pkg::MODE_CAPTURE;
        end else begin
            m = tacb_pkg::MODE_AUTORELOAD;
        end
        return m;
    endfunction

    // true when a write strobe hits the given address
    function automatic logic write_hit(input logic wr, input logic [7:0] a,
                                       input logic [7:0] target);
        return wr && (a == target);
    endfunction

    // combinational helpers
    tacb_pkg::tacb_mode_type mode;
    logic inc;          // one count step this cycle
    logic overflow;     // count rolls from all ones
    logic trig;         // qualified trigger edge
    logic hw_count;     // hardware changes the count this cycle
    logic hw_rcap;      // hardware changes the reload pair this cycle
    logic set_ovf;      // overflow flag set event
    logic set_ext;      // external flag set event

    // event decode, kept apart from the state update for readability
    always_comb begin
        mode = decode_mode(s_q.control);
        // increment source: pin edges or every core clock
        if (s_q.control[tacb_pkg::BIT_COUNTER_SELECT]) begin
            inc = count_edge.fall;
        end else begin
            inc = 1'b1;
        end
        // stopped timer never advances
        if (mode == tacb_pkg::MODE_OFF) begin
            inc = 1'b0;
        end
        overflow = inc && (s_q.count == tacb_pkg::COUNT_ALL_ONES);
        // trigger edges count only with the external enable set
        trig = trigger_edge.fall && s_q.control[tacb_pkg::BIT_EXTERNAL_ENABLE] &&
               (mode != tacb_pkg::MODE_OFF);
        // overflow flag is never set while a baud select bit is on
        set_ovf = overflow && (mode != tacb_pkg::MODE_BAUD);
        // external flag: capture, reload, or extra interrupt source in baud mode
        set_ext = trig;
        // hardware count updates: step, reload on rollover, reload on trigger
        hw_count = inc || (trig && (mode == tacb_pkg::MODE_AUTORELOAD));
        // hardware reload pair update only on capture
        hw_rcap = trig && (mode == tacb_pkg::MODE_CAPTURE);
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.rx_tick = 1'b0;
        s_d.tx_tick = 1'b0;
        s_d.rvalid = 1'b0;

        // software writes land first; hardware below overrides them
        if (write_hit(sfr_wr, sfr_addr, tacb_pkg::ADDR_CONTROL)) begin
            s_d.control = sfr_wdata;
        end
        if (write_hit(sfr_wr, sfr_addr, tacb_pkg::ADDR_COUNT_LOW)) begin
            s_d.count[7:0] = sfr_wdata;
        end
        if (write_hit(sfr_wr, sfr_addr, tacb_pkg::ADDR_COUNT_HIGH)) begin
            s_d.count[15:8] = sfr_wdata;
        end
        if (write_hit(sfr_wr, sfr_addr, tacb_pkg::ADDR_RCAP_LOW)) begin
            s_d.rcap[7:0] = sfr_wdata;
        end
        if (write_hit(sfr_wr, sfr_addr, tacb_pkg::ADDR_RCAP_HIGH)) begin
            s_d.rcap[15:8] = sfr_wdata;
        end

        // count update by hardware takes precedence over a byte write
        if (hw_count) begin
            case (mode)
                tacb_pkg::MODE_AUTORELOAD: begin
                    // rollover or trigger edge both reload the full 16 bits
                    if (overflow || trig) begin
                        s_d.count = s_q.rcap;
                    end else begin
                        s_d.count = s_q.count + 16'h0001;
                    end
                end
                tacb_pkg::MODE_CAPTURE: begin
                    // free running: wraps to zero, no reload
                    s_d.count = s_q.count + 16'h0001;
                end
                tacb_pkg::MODE_BAUD: begin
                    // forced autoreload regardless of the capture select bit
                    if (overflow) begin
                        s_d.count = s_q.rcap;
                    end else begin
                        s_d.count = s_q.count + 16'h0001;
                    end
                end
                default: begin
                    // off: hold the count
                    s_d.count = s_q.count;
                end
            endcase
        end

        // capture copies the current low and high count bytes
        if (hw_rcap) begin
            s_d.rcap = s_q.count;
        end

        // baud ticks: overflow pulses routed by the select bits
        if (overflow && (mode == tacb_pkg::MODE_BAUD)) begin
            s_d.rx_tick = s_q.control[tacb_pkg::BIT_RX_BAUD_SELECT];
            s_d.tx_tick = s_q.control[tacb_pkg::BIT_TX_BAUD_SELECT];
        end

        // flag sets win over a software clear in the same cycle
        if (set_ovf) begin
            s_d.control[tacb_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
        end
        if (set_ext) begin
            s_d.control[tacb_pkg::BIT_EXTERNAL_FLAG] = 1'b1;
        end

        // read answer, one cycle after the strobe
        if (sfr_rd) begin
            s_d.rvalid = 1'b1;
            case (sfr_addr)
                tacb_pkg::ADDR_CONTROL: begin
                    s_d.rdata = s_q.control;
                end
                tacb_pkg::ADDR_RCAP_LOW: begin
                    s_d.rdata = s_q.rcap[7:0];
                end
                tacb_pkg::ADDR_RCAP_HIGH: begin
                    s_d.rdata = s_q.rcap[15:8];
                end
                tacb_pkg::ADDR_COUNT_LOW: begin
                    s_d.rdata = s_q.count[7:0];
                end
                tacb_pkg::ADDR_COUNT_HIGH: begin
                    s_d.rdata = s_q.count[15:8];
                end
                default: begin
                    // other addresses belong to other peripherals
                    s_d.rdata = tacb_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q.control <= tacb_pkg::RESET_CONTROL;
            s_q.count <= tacb_pkg::RESET_COUNT;
            s_q.rcap <= tacb_pkg::RESET_RCAP;
            s_q.rdata <= tacb_pkg::READ_UNMAPPED;
            s_q.rvalid <= 1'b0;
            s_q.rx_tick <= 1'b0;
            s_q.tx_tick <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops; the overflow flag is never set in
    // baud mode, so only the external flag can raise a request there
    assign sfr_rdata = s_q.rdata;
    assign sfr_rvalid = s_q.rvalid;
    assign rx_baud_tick = s_q.rx_tick;
    assign tx_baud_tick = s_q.tx_tick;
    assign irq = s_q.control[tacb_pkg::BIT_OVERFLOW_FLAG] |
                 s_q.control[tacb_pkg::BIT_EXTERNAL_FLAG];

endmodule
`default_nettype wire

// ---- tb/tacb_pins.sv ----
// behavioural far side: drives the count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module tacb_pins (
    // clock
    input wire logic sys_clk,
    // one-cycle requests for a low pulse
    input wire logic cnt_go,
    input wire logic trg_go,
    // pins, idle high
    output var logic count_pin,
    output var logic trigger_pin
);
    int cnt_left = 0; // low cycles left on the count pin
    int trg_left = 0; // low cycles left on the trigger pin
    // three low cycles so the two-flop synchroniser cannot miss a pulse
    always @(posedge sys_clk) begin
        cnt_left <= cnt_go ? 3 : (cnt_left > 0 ? cnt_left - 1 : 0);
        trg_left <= trg_go ? 3 : (trg_left > 0 ? trg_left - 1 : 0);
    end
    assign count_pin = (cnt_left == 0);
    assign trigger_pin = (trg_left == 0);
endmodule
`default_nettype wire

// ---- tb/tacb_properties.sv ----
// port-level assertions for the timer with reload, capture and baud ticks
`timescale 1ns/1ps
`default_nettype none
module tacb_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    // pins, ticks and request
    input wire logic count_pin,
    input wire logic trigger_pin,
    input wire logic rx_baud_tick,
    input wire logic tx_baud_tick,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // shadow of software-only control bits {rx select, tx select, run}
    logic [2:0] sel_q;
    // hardware never touches these bits, so a write shadow is exact
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sel_q <= 3'h0;
        end else if (sfr_wr && sfr_addr == tacb_pkg::ADDR_CONTROL) begin
            sel_q <= {sfr_wdata[5:4], sfr_wdata[2]};
        end
    end
    a_read_answer: assert property (sfr_rvalid == $past(sfr_rd))
        else $error("read answer strobe out of step");
    a_rdata_holds: assert property (!sfr_rvalid |-> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (sfr_rvalid && !($past(sfr_addr) inside {8'hC8,
        [8'hCA:8'hCD]}) |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_irq_from_flags: assert property (sfr_rvalid && $past(sfr_addr) == 8'hC8
        |-> $past(irq) == (sfr_rdata[7] | sfr_rdata[6])) else $error("request not flag or");
    a_rx_tick_sel: assert property (rx_baud_tick |-> $past(sel_q[2] & sel_q[0]))
        else $error("receive tick without select and run");
    a_tx_tick_sel: assert property (tx_baud_tick |-> $past(sel_q[1] & sel_q[0]))
        else $error("transmit tick without select and run");
    a_tick_pair: assert property ($past(sel_q) == 3'h7 |-> rx_baud_tick == tx_baud_tick)
        else $error("ticks differ with both selects");
    a_baud_no_flag: assert property ((rx_baud_tick || tx_baud_tick) |-> !$rose(irq))
        else $error("overflow flag set in baud mode");
    a_flag_sticky: assert property ($past(irq) && !$past(sfr_wr) |-> irq)
        else $error("flag cleared without a write");
    // main scenarios
    c_both_ticks: cover property (rx_baud_tick && tx_baud_tick);
    c_irq_rise: cover property ($rose(irq));
    c_read_data: cover property (sfr_rvalid && sfr_rdata != 8'h00);
endmodule
bind tacb_timer tacb_properties u_tacb_properties (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq)
);
`default_nettype wire

// ---- tb/tacb_timer_tb.sv ----
// self-checking bench for the timer with reload, capture and baud ticks
`timescale 1ns/1ps
`default_nettype none
module tacb_timer_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata, got;
    logic sfr_rvalid, count_pin, trigger_pin, rx_baud_tick, tx_baud_tick, irq;
    logic cnt_go = 1'b0;
    logic trg_go = 1'b0;
    logic [31:0] seed = 32'hF5E35030;
    logic [7:0] amap[6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
    int fail_count = 0;
    int samples_checked = 0;
    int m_cnt, m_rcap, nrx, ntx; // register model and tick tallies kept as integers
    tacb_timer u_tacb_timer (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .sfr_rvalid(sfr_rvalid), .count_pin(count_pin), .trigger_pin(trigger_pin),
        .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq));
    tacb_pins u_tacb_pins (.sys_clk(sys_clk), .cnt_go(cnt_go), .trg_go(trg_go),
        .count_pin(count_pin), .trigger_pin(trigger_pin));
    // 250 MHz core clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // xorshift source of stimulus values
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // value comparison, case equality so unknowns fail
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // all drivers enter one time unit after a rising edge; the strobe stays
    // low across one edge so back-to-back calls never re-drive it in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_wr = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    // answer is registered, so it is visible just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_rd = 1'b0;
        chk("read strobe", 16'h0001, {15'h0000, sfr_rvalid});
        d = sfr_rdata;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rd16(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [7:0] lo;
        rd(a, lo);
        rd(a + 8'h01, got);
        chk(what, exp, {got, lo});
    endtask
    // one low pulse, then enough idle for the edge to act
    task automatic pulse(input bit trg);
        if (trg) trg_go = 1'b1;
        else cnt_go = 1'b1;
        @(posedge sys_clk);
        #1;
        trg_go = 1'b0;
        cnt_go = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    task automatic ticks(input int n);
        nrx = 0;
        ntx = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            nrx += rx_baud_tick;
            ntx += tx_baud_tick;
        end
    endtask
    task automatic results();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // a hang is cut short well beyond the few hundred cycles needed
    initial begin
        #40000;
        fail_count++;
        results();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        foreach (amap[i]) begin
            rd(amap[i], got);
            chk("reset value", 16'h0000, {8'h00, got});
        end
        seed = xs(seed);
        m_rcap = seed[15:0];
        wr(8'hCA, seed[7:0]);
        wr(8'hCB, seed[15:8]);
        rd16(8'hCA, m_rcap[15:0], "reload pair");
        wr(8'hCC, seed[23:16]);
        wr(8'hCD, seed[31:24]);
        rd16(8'hCC, seed[31:16], "count pair");
        // autoreload versus free-running overflow in timer mode
        for (int m = 0; m < 2; m++) begin
            wr(8'hCA, 8'hFE);
            wr(8'hCB, 8'hFF);
            wr(8'hCC, 8'hFD);
            wr(8'hCD, 8'hFF);
            wr(8'hC8, 8'h04 | m[7:0]);
            repeat (4) @(posedge sys_clk);
            #1;
            chk("irq", 16'h0001, {15'h0000, irq});
            rd(8'hC8, got);
            chk("control", 16'h0084 | m[15:0], {8'h00, got});
            wr(8'hC8, 8'h00);
            chk("irq", 16'h0000, {15'h0000, irq});
            rd(8'hCD, got);
            chk("count high", m ? 16'h0000 : 16'h00FF, {8'h00, got});
        end
        // baud mode per select pair; capture select must be ignored
        for (int s = 1; s < 4; s++) begin
            wr(8'hCC, 8'hFE);
            wr(8'hCD, 8'hFF);
            wr(8'hC8, 8'h05 | 8'(s << 4));
            ticks(4);
            ticks(20);
            chk("rx ticks", s[1] ? 16'h000A : 16'h0000, nrx[15:0]);
            chk("tx ticks", s[0] ? 16'h000A : 16'h0000, ntx[15:0]);
            chk("irq", 16'h0000, {15'h0000, irq});
            rd(8'hC8, got);
            chk("control", 16'h0005 | 16'(s << 4), {8'h00, got});
            wr(8'hC8, 8'h00);
        end
        // counter mode capture, trigger first ignored then honoured
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        seed = xs(seed);
        m_cnt = seed[2:0] + 1;
        wr(8'hC8, 8'h07);
        repeat (m_cnt) pulse(0);
        pulse(1);
        rd(8'hC8, got);
        chk("control", 16'h0007, {8'h00, got});
        rd16(8'hCA, 16'hFFFE, "reload pair");
        wr(8'hC8, 8'h0F);
        pulse(1);
        rd(8'hC8, got);
        chk("control", 16'h004F, {8'h00, got});
        rd16(8'hCA, m_cnt[15:0], "captured count");
        // trigger reload in autoreload mode, then nothing while stopped
        m_rcap = seed[31:16];
        wr(8'hCA, seed[23:16]);
        wr(8'hCB, seed[31:24]);
        wr(8'hC8, 8'h0E);
        pulse(1);
        rd(8'hC8, got);
        chk("control", 16'h004E, {8'h00, got});
        rd16(8'hCC, m_rcap[15:0], "reloaded count");
        wr(8'hC8, 8'h0A);
        pulse(0);
        pulse(1);
        rd(8'hC8, got);
        chk("control", 16'h000A, {8'h00, got});
        rd16(8'hCC, m_rcap[15:0], "stopped count");
        // reset in mid-run returns control and count to zero
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk("irq", 16'h0000, {15'h0000, irq});
        rd(8'hC8, got);
        chk("control", 16'h0000, {8'h00, got});
        rd16(8'hCC, 16'h0000, "reset count");
        results();
    end
endmodule
`default_nettype wire
